// *** core/cwa_config_word_access.sv ***
// Configuration fuse storage, table access, mode decode and start-up hold
`timescale 1ns/100ps
module cwa_config_word_access #(
   parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = cwa_pkg::POWERUP_DELAY_TIMER_CYCLES
) (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  clkEn,
   input  wire logic                  fuseErase,
   input  wire logic                  powerOnPin,
   input  wire logic                  brownoutPin,
   input  wire cwa_pkg::cwa_tbl_req_t  tblReq,
   input  wire cwa_pkg::cwa_prog_req_t progReq,
   output logic [7:0]                 tableLatchLow_ff,
   output logic [7:0]                 tableLatchHigh_ff,
   output logic                       tblDone_ff,
   output logic                       tblHit_ff,
   output logic [7:0]                 progData_ff,
   output logic                       progDone_ff,
   output cwa_pkg::cwa_proc_mode_t     procMode_ff,
   output cwa_pkg::cwa_osc_mode_t      oscMode_ff,
   output logic [1:0]                 watchdogPostscale_ff,
   output logic                       watchdogEnable_ff,
   output logic                       brownoutDetectEnable_ff,
   output logic                       deviceHold_ff
);
   // Fuse storage is non-volatile: only an erase returns it to blank
   logic [7:0]              cfgBits_ff;
   logic [7:0]              nxt_cfgBits;
   cwa_pkg::cwa_tbl_state_t state_ff;
   cwa_pkg::cwa_tbl_state_t nxt_state;
   logic [15:0]             tblAddr_ff;
   logic [1:0]              porSync_ff;
   logic [1:0]              borSync_ff;
   logic                    porPrev_ff;
   logic                    borPrev_ff;

   // Field views of the stored fuses
   wire [1:0] oscSel  = {cfgBits_ff[cwa_pkg::IDX_OSC1], cfgBits_ff[cwa_pkg::IDX_OSC0]};
   wire [1:0] wdpsSel = {cfgBits_ff[cwa_pkg::IDX_WDPS1], cfgBits_ff[cwa_pkg::IDX_WDPS0]};
   wire [2:0] pmSel   = {cfgBits_ff[cwa_pkg::IDX_PM2], cfgBits_ff[cwa_pkg::IDX_PM1],
                         cfgBits_ff[cwa_pkg::IDX_PM0]};
   wire       brownout_detect_enable   = cfgBits_ff[cwa_pkg::IDX_BOD];

   // Returned bytes, blank positions forced high
   wire [7:0] lowByte  = {1'b1, cfgBits_ff[cwa_pkg::IDX_PM1], 1'b1,
                          cfgBits_ff[cwa_pkg::IDX_PM0], wdpsSel, oscSel};
   wire [7:0] highByte = {cfgBits_ff[cwa_pkg::IDX_PM2], brownout_detect_enable,
                          cwa_pkg::HIGH_UNUSED};

   // CPU address decode
   wire cpuInRange  = (tblReq.addr[15:4] == cwa_pkg::CFG_BASE_HI);
   wire cpuModeOk   = (pmSel == cwa_pkg::PM_MICROCTRL) || (pmSel == cwa_pkg::PM_CODE_PROT);
   wire cpuHit      = cpuInRange && cpuModeOk;
   wire heldInRange = (tblAddr_ff[15:4] == cwa_pkg::CFG_BASE_HI);
   wire heldHit     = heldInRange && cpuModeOk;
   wire [7:0] cpuByte = tblAddr_ff[3] ? highByte : lowByte;

   cwa_pkg::cwa_loc_t cpuLoc;
   cwa_pkg::cwa_loc_t progLoc;
   assign cpuLoc  = cwa_pkg::cwa_loc_decode(tblAddr_ff[3:0]);
   assign progLoc = cwa_pkg::cwa_loc_decode(progReq.loc);

   // Write data is ignored: a write can only blow a fuse to 0
   wire       cpuProgram  = (state_ff == cwa_pkg::ST_WRITE) && heldHit && cpuLoc.valid;
   wire       progProgram = progReq.wr && progLoc.valid;
   wire [7:0] cpuMask     = cpuProgram ? (8'h01 << cpuLoc.idx) : 8'h00;
   wire [7:0] progMask    = progProgram ? (8'h01 << progLoc.idx) : 8'h00;
   assign nxt_cfgBits = fuseErase ? cwa_pkg::CFG_BLANK
                                  : (cfgBits_ff & ~(cpuMask | progMask));

   // Table access sequencer: reads and writes take two cycles
   always_comb begin
      nxt_state = cwa_pkg::ST_IDLE;
      case (state_ff)
         cwa_pkg::ST_IDLE: begin
            if (tblReq.rd) begin
               nxt_state = cwa_pkg::ST_READ;
            end else if (tblReq.wr) begin
               nxt_state = cwa_pkg::ST_WRITE;
            end
         end
         cwa_pkg::ST_READ: nxt_state = cwa_pkg::ST_IDLE;
         cwa_pkg::ST_WRITE: nxt_state = cwa_pkg::ST_IDLE;
         default: nxt_state = cwa_pkg::ST_IDLE;
      endcase
   end

   wire takeReq  = (state_ff == cwa_pkg::ST_IDLE) && (tblReq.rd || tblReq.wr);
   wire readLast = (state_ff == cwa_pkg::ST_READ);
   wire anyLast  = readLast || (state_ff == cwa_pkg::ST_WRITE);

   // Mode decode
   cwa_pkg::cwa_proc_mode_t nxt_procMode;
   assign nxt_procMode = (pmSel == cwa_pkg::PM_MICROPROC) ? cwa_pkg::MODE_MICROPROC :
                         (pmSel == cwa_pkg::PM_MICROCTRL) ? cwa_pkg::MODE_MICROCTRL :
                         (pmSel == cwa_pkg::PM_EXTENDED)  ? cwa_pkg::MODE_EXTENDED  :
                         (pmSel == cwa_pkg::PM_CODE_PROT) ? cwa_pkg::MODE_CODE_PROT :
                                                            cwa_pkg::MODE_RESERVED;
   cwa_pkg::cwa_osc_mode_t nxt_oscMode;
   assign nxt_oscMode = cwa_pkg::cwa_osc_mode_t'(oscSel);

   // The watchdog itself runs on its own oscillator; only the fuses can stop it
   wire nxt_wdEnable = (wdpsSel != cwa_pkg::WDPS_DISABLED);

   // Start-up events from pins, edge detected after synchronising
   wire porEvent    = porSync_ff[1] && !porPrev_ff;
   wire borEvent    = borSync_ff[1] && !borPrev_ff && brownout_detect_enable;
   wire crystalMode = (oscSel == cwa_pkg::OSC_CRYSTAL_RES) ||
                      (oscSel == cwa_pkg::OSC_LOW_POWER_CRYSTAL);
   wire ostStart    = (porEvent || borEvent) && crystalMode;
   logic pwrtBusy;
   logic ostBusy;

   cwa_delay_timer #(
      .CYCLES (POWERUP_DELAY_TIMER_CYCLES),
      .WIDTH  (cwa_pkg::TIMER_WIDTH)
   ) u_powerup_delay_timer (
      .clk     (clk),
      .reset   (reset),
      .clkEn   (clkEn),
      .start   (porEvent),
      .busy_ff (pwrtBusy)
   );

   cwa_delay_timer #(
      .CYCLES (cwa_pkg::OST_CYCLES),
      .WIDTH  (cwa_pkg::TIMER_WIDTH)
   ) u_ost (
      .clk     (clk),
      .reset   (reset),
      .clkEn   (clkEn),
      .start   (ostStart),
      .busy_ff (ostBusy)
   );

   wire nxt_hold = porEvent || borEvent || pwrtBusy || ostBusy;

   always_ff @(posedge clk) begin
      if (clkEn) begin
         cfgBits_ff <= nxt_cfgBits;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         porSync_ff <= 2'h0;
         borSync_ff <= 2'h0;
         porPrev_ff <= 1'b0;
         borPrev_ff <= 1'b0;
      end else if (clkEn) begin
         porSync_ff <= {porSync_ff[0], powerOnPin};
         borSync_ff <= {borSync_ff[0], brownoutPin};
         porPrev_ff <= porSync_ff[1];
         borPrev_ff <= borSync_ff[1];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff   <= cwa_pkg::ST_IDLE;
         tblAddr_ff <= 16'h0000;
         tblDone_ff <= 1'b0;
         tblHit_ff  <= 1'b0;
      end else if (clkEn) begin
         state_ff   <= nxt_state;
         tblAddr_ff <= takeReq ? tblReq.addr : tblAddr_ff;
         tblDone_ff <= anyLast;
         tblHit_ff  <= anyLast && heldHit;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tableLatchLow_ff  <= 8'h00;
         tableLatchHigh_ff <= 8'h00;
      end else if (clkEn && readLast && heldHit) begin
         tableLatchLow_ff  <= cpuByte;
         tableLatchHigh_ff <= cwa_pkg::HIGH_LATCH_FILL;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         progData_ff <= 8'h00;
         progDone_ff <= 1'b0;
      end else if (clkEn) begin
         progDone_ff <= progReq.rd || progReq.wr;
         if (progReq.rd) begin
            progData_ff <= progReq.loc[3] ? highByte : lowByte;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         deviceHold_ff <= 1'b1;
      end else if (clkEn) begin
         deviceHold_ff <= nxt_hold;
      end
   end

   always_ff @(posedge clk) begin
      if (clkEn) begin
         procMode_ff             <= nxt_procMode;
         oscMode_ff              <= nxt_oscMode;
         watchdogPostscale_ff    <= wdpsSel;
         watchdogEnable_ff       <= nxt_wdEnable;
         brownoutDetectEnable_ff <= brownout_detect_enable;
      end
   end

endmodule : cwa_config_word_access

// *** core/cwa_delay_timer.sv ***
// Down-counting delay timer that reports busy until its count expires
`timescale 1ns/100ps
module cwa_delay_timer #(
   parameter int unsigned CYCLES = 1024,
   parameter int unsigned WIDTH  = 20
) (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic clkEn,
   input  wire logic start,
   output logic      busy_ff
);
   logic [WIDTH-1:0] count_ff;
   logic [WIDTH-1:0] nxt_count;
   logic             nxt_busy;
   wire              lastCycle = (count_ff == '0);

   assign nxt_busy  = start ? 1'b1 : (busy_ff && !lastCycle);
   assign nxt_count = start ? WIDTH'(CYCLES - 1) : (busy_ff ? count_ff - 1'b1 : count_ff);

   always_ff @(posedge clk) begin
      if (reset) begin
         busy_ff  <= 1'b0;
         count_ff <= '0;
      end else if (clkEn) begin
         busy_ff  <= nxt_busy;
         count_ff <= nxt_count;
      end
   end
endmodule : cwa_delay_timer

// *** include/cwa_pkg.sv ***
// Constants, types and helpers shared by the configuration word block
// Overview of operation
// - Eight fuse bits: programmed 0, blank 1
// - Any write programs the bit to 0
// - FE00h-FE07h read: low byte, high latch FFh
// - FE08h-FE0Fh read: high byte, high latch FFh
// - CPU sees fuses only in microcontroller modes
// - Programmer reads fuses in any mode
// - Fixed address of every fuse bit
// - Decode mode: 111,110,101,000
// - Decode oscillator: 11,10,01,00
// - Watchdog disabled only by fuses, own oscillator
// - Power-up delay 96 ms, power-up only
// - Start-up timer on power-on and brown-out
// - Postscale 00 disables watchdog permanently
// - Crystal modes hold reset 1024 periods
package cwa_pkg;

   localparam logic [11:0] CFG_BASE_HI     = 12'hFE0;
   localparam logic [15:0] CFG_LOW_OFFSET  = 16'hFE00;
   localparam logic [15:0] CFG_HIGH_OFFSET = 16'hFE08;
   localparam logic [7:0]  HIGH_LATCH_FILL = 8'hFF;
   localparam logic [7:0]  CFG_BLANK       = 8'hFF;
   localparam logic [5:0]  HIGH_UNUSED     = 6'h3F;

   // Bit positions inside the stored fuse vector
   localparam int unsigned IDX_OSC0  = 0;
   localparam int unsigned IDX_OSC1  = 1;
   localparam int unsigned IDX_WDPS0 = 2;
   localparam int unsigned IDX_WDPS1 = 3;
   localparam int unsigned IDX_PM0   = 4;
   localparam int unsigned IDX_PM1   = 5;
   localparam int unsigned IDX_BOD   = 6;
   localparam int unsigned IDX_PM2   = 7;

   // Location offsets inside the 16-word window
   localparam logic [3:0] LOC_OSC0  = 4'h0;
   localparam logic [3:0] LOC_OSC1  = 4'h1;
   localparam logic [3:0] LOC_WDPS0 = 4'h2;
   localparam logic [3:0] LOC_WDPS1 = 4'h3;
   localparam logic [3:0] LOC_PM0   = 4'h4;
   localparam logic [3:0] LOC_PM1   = 4'h6;
   localparam logic [3:0] LOC_BOD   = 4'hE;
   localparam logic [3:0] LOC_PM2   = 4'hF;

   localparam logic [2:0] PM_MICROPROC  = 3'h7;
   localparam logic [2:0] PM_MICROCTRL  = 3'h6;
   localparam logic [2:0] PM_EXTENDED   = 3'h5;
   localparam logic [2:0] PM_CODE_PROT  = 3'h0;
   localparam logic [1:0] WDPS_DISABLED = 2'h0;

   // Timing
   localparam longint unsigned CLK_HZ          = 64'd10_000_000;
   localparam longint unsigned POWERUP_DELAY_TIMER_TIME_MS    = 64'd96;
   localparam int unsigned     POWERUP_DELAY_TIMER_CYCLES     = int'(POWERUP_DELAY_TIMER_TIME_MS * CLK_HZ / 64'd1000);
   localparam int unsigned     OST_OSC_PERIODS = 1024;
   localparam int unsigned     OST_CYCLES      = OST_OSC_PERIODS;
   localparam int unsigned     TIMER_WIDTH     = 20;

   typedef enum logic [1:0] {
      OSC_LOW_POWER_CRYSTAL = 2'h0,
      OSC_RES_CAP           = 2'h1,
      OSC_CRYSTAL_RES       = 2'h2,
      OSC_EXTERNAL_CLOCK    = 2'h3
   } cwa_osc_mode_t;

   typedef enum logic [4:0] {
      MODE_MICROPROC = 5'h01,
      MODE_MICROCTRL = 5'h02,
      MODE_EXTENDED  = 5'h04,
      MODE_CODE_PROT = 5'h08,
      MODE_RESERVED  = 5'h10
   } cwa_proc_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_READ  = 3'h2,
      ST_WRITE = 3'h4
   } cwa_tbl_state_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
   } cwa_tbl_req_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [3:0] loc;
   } cwa_prog_req_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] idx;
   } cwa_loc_t;

   function automatic cwa_loc_t cwa_loc_decode(input logic [3:0] loc);
      cwa_loc_t r;
      r.valid = 1'b1;
      r.idx   = 3'h0;
      if (loc == LOC_OSC0) r.idx = 3'(IDX_OSC0);
      else if (loc == LOC_OSC1) r.idx = 3'(IDX_OSC1);
      else if (loc == LOC_WDPS0) r.idx = 3'(IDX_WDPS0);
      else if (loc == LOC_WDPS1) r.idx = 3'(IDX_WDPS1);
      else if (loc == LOC_PM0) r.idx = 3'(IDX_PM0);
      else if (loc == LOC_PM1) r.idx = 3'(IDX_PM1);
      else if (loc == LOC_BOD) r.idx = 3'(IDX_BOD);
      else if (loc == LOC_PM2) r.idx = 3'(IDX_PM2);
      else r.valid = 1'b0;
      return r;
   endfunction : cwa_loc_decode

endpackage : cwa_pkg

// *** verif/cwa_config_word_access_assertions.sv ***
// Port checker for the configuration word block
`timescale 1ns/100ps
module cwa_config_word_access_assertions #(
   parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = cwa_pkg::POWERUP_DELAY_TIMER_CYCLES
) (
   input wire logic                   clk,
   input wire logic                   reset,
   input wire logic                   clkEn,
   input wire logic                   fuseErase,
   input wire logic                   powerOnPin,
   input wire logic                   brownoutPin,
   input wire cwa_pkg::cwa_tbl_req_t  tblReq,
   input wire cwa_pkg::cwa_prog_req_t progReq,
   input wire logic [7:0]             tableLatchLow_ff,
   input wire logic [7:0]             tableLatchHigh_ff,
   input wire logic                   tblDone_ff,
   input wire logic                   tblHit_ff,
   input wire logic [7:0]             progData_ff,
   input wire logic                   progDone_ff,
   input wire cwa_pkg::cwa_proc_mode_t procMode_ff,
   input wire cwa_pkg::cwa_osc_mode_t  oscMode_ff,
   input wire logic [1:0]             watchdogPostscale_ff,
   input wire logic                   watchdogEnable_ff,
   input wire logic                   brownoutDetectEnable_ff,
   input wire logic                   deviceHold_ff
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_hit_done: assert property (tblHit_ff |-> tblDone_ff)
      else $error("hit without done");
   a_done_take: assert property (tblDone_ff |-> $past(tblReq.rd || tblReq.wr, 2))
      else $error("done without request");
   a_high_fill: assert property (tblHit_ff && $past(tblReq.rd, 2) |-> tableLatchHigh_ff == 8'hFF)
      else $error("high latch not FF");
   a_miss_keep: assert property (tblDone_ff && !tblHit_ff |-> $stable(tableLatchLow_ff))
      else $error("latch changed on miss");
   a_mode_gate: assert property (tblHit_ff |-> $past(procMode_ff, 2) inside
      {cwa_pkg::MODE_MICROCTRL, cwa_pkg::MODE_CODE_PROT})
      else $error("hit in wrong mode");
   a_prog_ack: assert property (clkEn && (progReq.rd || progReq.wr) |=> progDone_ff)
      else $error("programmer not acknowledged");
   a_high_pad: assert property (progDone_ff && $past(progReq.rd && progReq.loc[3])
      |-> progData_ff[5:0] == 6'h3F)
      else $error("unused high bits not 1");
   a_wdt_off: assert property (watchdogEnable_ff == (watchdogPostscale_ff != 2'h0))
      else $error("watchdog enable wrong");
   a_hold_run: assert property ($rose(deviceHold_ff) |=> deviceHold_ff [*8])
      else $error("hold too short");
   c_hit: cover property (tblHit_ff);
   c_prog_wr: cover property (progDone_ff && $past(progReq.wr));
   c_hold_end: cover property ($fell(deviceHold_ff));
endmodule : cwa_config_word_access_assertions

bind cwa_config_word_access cwa_config_word_access_assertions
   #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES)) u_chk (.*);

// *** verif/cwa_config_word_access_test.sv ***
// Self-checking bench for the configuration word block
`timescale 1ns/100ps
module cwa_config_word_access_test;
   localparam int PW = 50;
   logic clk = 1'b0, reset = 1'b1, fuseErase = 1'b1, powerOnPin = 1'b0, brownoutPin = 1'b0;
   logic clkEn = 1'b1;
   cwa_pkg::cwa_tbl_req_t  tblReq;
   cwa_pkg::cwa_prog_req_t progReq;
   cwa_pkg::cwa_proc_mode_t mode;
   cwa_pkg::cwa_osc_mode_t  osc;
   logic [7:0] lowLatch, highLatch, progData;
   logic [1:0] wdPs, r;
   logic       tblDone, tblHit, progDone, wdEn, brownout_detect_enable, hold, ok;
   int         bad_count = 0, comparisons = 0;
   always #50 clk = ~clk;
   cwa_config_word_access #(.POWERUP_DELAY_TIMER_CYCLES(PW)) dut (.clk(clk), .reset(reset), .clkEn(clkEn),
      .fuseErase(fuseErase), .powerOnPin(powerOnPin), .brownoutPin(brownoutPin),
      .tblReq(tblReq), .progReq(progReq), .tableLatchLow_ff(lowLatch),
      .tableLatchHigh_ff(highLatch), .tblDone_ff(tblDone), .tblHit_ff(tblHit),
      .progData_ff(progData), .progDone_ff(progDone), .procMode_ff(mode), .oscMode_ff(osc),
      .watchdogPostscale_ff(wdPs), .watchdogEnable_ff(wdEn),
      .brownoutDetectEnable_ff(brownout_detect_enable), .deviceHold_ff(hold));
   cwa_host_model host (.clk(clk), .tblDone_ff(tblDone), .tblHit_ff(tblHit),
      .progDone_ff(progDone), .tblReq(tblReq), .progReq(progReq));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   task automatic erase;
      @(posedge clk) #1 fuseErase = 1'b1;
      @(posedge clk) #1 fuseErase = 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : erase
   task automatic pw(input logic [3:0] loc);
      host.prog(1'b1, loc, ok);
      chk("prog ack", 8'h01, ok);
      repeat (2) @(posedge clk);
      #1;
   endtask : pw
   task automatic pr(input logic [3:0] loc, input logic [7:0] exp);
      host.prog(1'b0, loc, ok);
      chk("prog data", exp, progData);
   endtask : pr
   task automatic rd(input logic [15:0] a, input logic [1:0] er, input logic [7:0] el);
      host.cpu(1'b0, a, r);
      chk("tbl status", er, r);
      if (er[0]) begin
         chk("low latch", el, lowLatch);
         chk("high latch", 8'hFF, highLatch);
      end
   endtask : rd
   task automatic cw(input logic [15:0] a);
      host.cpu(1'b1, a, r);
      chk("tbl status", 8'h03, r);
      repeat (2) @(posedge clk);
      #1;
   endtask : cw
   // Counts held cycles after a pin rise
   task automatic hc(input logic bo, input int lo, input int hi);
      int n;
      n = 0;
      @(posedge clk) #1;
      if (bo) brownoutPin = 1'b1;
      else powerOnPin = 1'b1;
      repeat (1200) begin
         @(posedge clk) #1;
         if (hold === 1'b1) n++;
      end
      brownoutPin = 1'b0;
      powerOnPin = 1'b0;
      chk("hold span", 8'h01, n >= lo && n <= hi);
   endtask : hc
   task automatic t_modes;
      erase();
      chk("mode", cwa_pkg::MODE_MICROPROC, mode);
      chk("osc", cwa_pkg::OSC_EXTERNAL_CLOCK, osc);
      rd(16'hFE00, 2'b10, 8'h00);
      pr(4'h0, 8'hFF);
      pw(4'h4);
      chk("mode", cwa_pkg::MODE_MICROCTRL, mode);
      rd(16'hFE07, 2'b11, 8'hEF);
      erase();
      pw(4'h6);
      chk("mode", cwa_pkg::MODE_EXTENDED, mode);
      rd(16'hFE08, 2'b10, 8'h00);
      erase();
      pw(4'h4);
      chk("mode", cwa_pkg::MODE_MICROCTRL, mode);
      pw(4'h6);
      chk("mode", cwa_pkg::MODE_RESERVED, mode);
      pw(4'hF);
      chk("mode", cwa_pkg::MODE_CODE_PROT, mode);
      rd(16'hFE0F, 2'b11, 8'h7F);
      rd(16'hFE10, 2'b10, 8'h00);
      pr(4'h8, 8'h7F);
      $display("test modes done");
   endtask : t_modes
   // Locations are always programmed upward; each group starts with an erase, so from blank fuses
   task automatic t_writes;
      erase();
      clkEn = 1'b0;
      host.prog(1'b1, 4'h0, ok);
      chk("frozen ack", 8'h00, ok);
      repeat (2) @(posedge clk);
      #1;
      chk("frozen osc", cwa_pkg::OSC_EXTERNAL_CLOCK, osc);
      clkEn = 1'b1;
      pw(4'h1);
      chk("osc", cwa_pkg::OSC_RES_CAP, osc);
      erase();
      pw(4'h0);
      pw(4'h1);
      chk("osc", cwa_pkg::OSC_LOW_POWER_CRYSTAL, osc);
      pw(4'h2);
      chk("wd enable", 8'h01, wdEn);
      pw(4'h3);
      chk("wd enable", 8'h00, wdEn);
      pw(4'h4);
      cw(16'hFE05);
      rd(16'hFE00, 2'b11, 8'hE0);
      cw(16'hFE0E);
      rd(16'hFE08, 2'b11, 8'hBF);
      chk("bod", 8'h00, brownout_detect_enable);
      $display("test writes done");
   endtask : t_writes
   task automatic t_timers;
      erase();
      pw(4'h0);
      chk("osc", cwa_pkg::OSC_CRYSTAL_RES, osc);
      hc(1'b0, 1024, 1080);
      hc(1'b1, 1024, 1030);
      erase();
      hc(1'b0, PW, PW + 4);
      pw(4'hE);
      hc(1'b1, 0, 0);
      $display("test timers done");
   endtask : t_timers
   initial begin
      repeat (6) @(posedge clk);
      #1 reset = 1'b0;
      fuseErase = 1'b0;
      t_modes();
      t_writes();
      t_timers();
      results();
   end
   initial begin
      #2_000_000;
      bad_count++;
      results();
   end
endmodule : cwa_config_word_access_test

// *** verif/cwa_host_model.sv ***
// CPU table path and device programmer facing the block
`timescale 1ns/100ps
module cwa_host_model (
   input  wire logic              clk,
   input  wire logic              tblDone_ff,
   input  wire logic              tblHit_ff,
   input  wire logic              progDone_ff,
   output cwa_pkg::cwa_tbl_req_t  tblReq,
   output cwa_pkg::cwa_prog_req_t progReq
);
   initial begin
      tblReq = '0;
      progReq = '0;
   end
   // Table instruction held until done; released address is inverted
   task automatic cpu(input logic wr, input logic [15:0] a, output logic [1:0] r);
      int n;
      @(posedge clk) #1;
      tblReq = {~wr, wr, a};
      n = 0;
      do begin
         @(posedge clk) #1;
         n++;
      end while (tblDone_ff !== 1'b1 && n < 8);
      r = {tblDone_ff, tblHit_ff};
      tblReq = {2'b00, ~a};
   endtask : cpu
   // Callers program locations upward after each erase; reads may go back down
   task automatic prog(input logic wr, input logic [3:0] loc, output logic ok);
      @(posedge clk) #1;
      progReq = {~wr, wr, loc};
      @(posedge clk) #1;
      ok = progDone_ff;
      progReq = {2'b00, ~loc};
   endtask : prog
endmodule : cwa_host_model
